// ---- design/amp_regs_params.svh ----
// Register offsets, field positions and reset values of the amplifier status and ramp control bank
`ifndef AMP_REGS_PARAMS_SVH
`define AMP_REGS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_PIN_OUTPUT_POLARITY      8'h66
`define OFS_CHIP_IDENTIFIER          8'h67
`define OFS_POWER_STATE_REPORT       8'h68
`define OFS_AUTO_SILENCE_STATUS      8'h69
`define OFS_RAMP_PHASE_CONTROL       8'h6A
`define OFS_SPREAD_SPECTRUM_CONTROL_A 8'h6B
`define OFS_SPREAD_SPECTRUM_CONTROL_B 8'h6C

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PIN_OUTPUT_POLARITY      8'h00
`define RST_POWER_STATE_REPORT       8'h00
`define RST_AUTO_SILENCE_STATUS      8'h00
`define RST_RAMP_PHASE_CONTROL       8'h00
`define RST_SPREAD_SPECTRUM_CONTROL_A 8'h00
`define RST_SPREAD_SPECTRUM_CONTROL_B 8'h00
`define RST_READ_DATA                8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_INV_PIN1                 0
`define BIT_INV_PIN2                 1
`define BIT_INV_PIN0                 2
`define BIT_LEFT_SILENCE             0
`define BIT_RIGHT_SILENCE            1
`define BIT_PHASE_SYNC_EN            0
`define BIT_PHASE_SYNC_SRC           1
`define FLD_RAMP_PHASE_LSB           2
`define FLD_RAMP_PHASE_MSB           3
`define BIT_TRIANGLE_SPREAD_EN       0
`define BIT_RANDOM_SPREAD_EN         1
`define BIT_SPREAD_MANUAL            4
`define BIT_SPREAD_PRE_DIV           5
`define FLD_TRIANGLE_CTRL_LSB        0
`define FLD_TRIANGLE_CTRL_MSB        3
`define FLD_RANDOM_DITHER_LSB        4
`define FLD_RANDOM_DITHER_MSB        6

// ----------------------------------------------------------------------------
// Ramp phase step in degrees
// ----------------------------------------------------------------------------
`define RAMP_PHASE_STEP_DEG          8'h2D

`endif

// ---- design/amp_regs_pkg.sv ----
// Types shared by the amplifier status and ramp control bank
`default_nettype none

package amp_regs_pkg;

    typedef logic [7:0] byte_t;

    typedef logic [2:0] pin_vec_t;

    // Order gives the reported codes 0 to 3
    typedef enum logic [1:0] {
        pwr_deep_sleep,
        pwr_sleep,
        pwr_hiz,
        pwr_play
    } power_state_t;

endpackage

`default_nettype wire

// ---- design/pin_polarity.sv ----
// Output polarity stage for the three general pins
`timescale 1ns/10ps
`default_nettype none

module pin_polarity
(
    input  wire logic                    clk_sys,    // System clock
    input  wire logic                    rst_b,      // Async reset, active low
    input  wire amp_regs_pkg::pin_vec_t  invert,     // Invert per pin, pin index order
    input  wire amp_regs_pkg::pin_vec_t  level_in,   // Core output level per pin
    input  wire amp_regs_pkg::pin_vec_t  oe_in,      // Core output enable per pin
    output logic [2:0]                   pin_out_q,  // Driven pin level
    output logic [2:0]                   pin_oe_q    // Pin output enable, high drives
);
    import amp_regs_pkg::*;

    // ------------------------------------------------------------------------
    // Polarity
    // ------------------------------------------------------------------------
    // An input pin is left undriven and its level held low so inversion cannot leak
    wire pin_vec_t pin_out_d = (level_in ^ invert) & oe_in;
    wire pin_vec_t pin_oe_d  = oe_in;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out_q <= 3'h0;
            pin_oe_q  <= 3'h0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end

endmodule

`default_nettype wire

// ---- design/ramp_phase_sync.sv ----
// Ramp phase selection and phase synchronisation pulse
`timescale 1ns/10ps
`include "amp_regs_params.svh"
`default_nettype none

module ramp_phase_sync
(
    input  wire logic        clk_sys,          // System clock
    input  wire logic        rst_b,            // Async reset, active low
    input  wire logic [1:0]  phase_sel,        // Programmed ramp phase
    input  wire logic        sync_en,          // Phase sync enable
    input  wire logic        sync_src_internal,// 1 internal source, 0 pin
    input  wire logic        sync_pin,         // Sync pin, asynchronous
    input  wire logic        internal_sync,    // Internal sync pulse, same clock
    input  wire logic        in_play,          // Device is in play state
    output logic [1:0]       ramp_phase_q,     // Phase in use by the ramp
    output logic [7:0]       ramp_phase_deg_q, // Phase offset in degrees
    output logic             ramp_sync_q       // One-cycle phase sync pulse
);
    import amp_regs_pkg::*;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic byte_t phase_to_deg(input logic [1:0] ph);
        phase_to_deg = 8'({6'h00, ph} * `RAMP_PHASE_STEP_DEG);
    endfunction

    // ------------------------------------------------------------------------
    // Sync pin crossing and edge detect
    // ------------------------------------------------------------------------
    logic sync_meta_q;
    logic sync_stable_q;
    logic sync_prev_q;

    wire logic pin_rise    = sync_stable_q & ~sync_prev_q;
    wire logic sync_source = sync_src_internal ? internal_sync : pin_rise;
    wire logic sync_d      = sync_en & sync_source;

    // Phase is frozen during play so a late write cannot jerk a running ramp
    wire logic [1:0] phase_d = in_play ? ramp_phase_q : phase_sel;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_meta_q      <= 1'b0;
            sync_stable_q    <= 1'b0;
            sync_prev_q      <= 1'b0;
            ramp_sync_q      <= 1'b0;
            ramp_phase_q     <= 2'h0;
            ramp_phase_deg_q <= 8'h00;
        end
        else
        begin
            sync_meta_q      <= sync_pin;
            sync_stable_q    <= sync_meta_q;
            sync_prev_q      <= sync_stable_q;
            ramp_sync_q      <= sync_d;
            ramp_phase_q     <= phase_d;
            ramp_phase_deg_q <= phase_to_deg(phase_d);
        end
    end

endmodule

`default_nettype wire

// ---- design/amp_status_ramp_ss_regs.sv ----
// Status, pin polarity, ramp phase and spread-spectrum register bank
//
// Operation
// - Polarity bit 0 inverts pin 1, bit 1 pin 2, bit 2 pin 0.
// - Eight-bit read-only chip identifier, fixed value, unchanged by writes.
// - Power report reads 0 deep sleep, 1 sleep, 2 high-impedance, 3 play.
// - Status bit 1 reads 1 while right channel is auto-muted.
// - Status bit 0 reads 1 while left channel is auto-muted.
// - Two-bit ramp phase selects phase 0 to 3, 45 degrees apart.
// - Sync source bit picks pin sync at 0, internal sync at 1.
// - Phase control bit 0 enables ramp phase sync; cleared, none applied.
// - In manual mode bit 5 selects PLL clock divided by two.
// - Bit 4 puts the spread controller in manual mode, else default.
// - Bit 1 enables random spread, bit 0 triangle spread; reset 0.
// - Bits 6 to 4 of second register set random dither, reset 000.
// - Bits 3 to 0 of second register set triangle control, reset 0000.
`timescale 1ns/10ps
`include "amp_regs_params.svh"
`default_nettype none

module amp_status_ramp_ss_regs
#(
    parameter logic [7:0] CHIP_ID = 8'h5A        // Arbitrary identifier value
)
(
    input  wire logic                    clk_sys,          // System clock, 20 MHz
    input  wire logic                    rst_b,            // Async reset, active low
    input  wire amp_regs_pkg::byte_t     reg_addr,         // Register offset
    input  wire amp_regs_pkg::byte_t     reg_wdata,        // Write data
    input  wire logic                    reg_wr,           // Write strobe, one cycle
    input  wire logic                    reg_rd,           // Read strobe, one cycle
    output logic [7:0]                   reg_rdata_q,      // Read data
    output logic                         reg_rvalid_q,     // Read data valid pulse
    input  wire amp_regs_pkg::byte_t     power_state_in,   // Power state code from core
    input  wire logic                    right_silent_in,  // Right channel auto-muted
    input  wire logic                    left_silent_in,   // Left channel auto-muted
    input  wire amp_regs_pkg::pin_vec_t  pin_level_in,     // Pin output levels from core
    input  wire amp_regs_pkg::pin_vec_t  pin_dir_out_in,   // Pin is an output, per pin
    output logic [2:0]                   pin_out_q,        // Driven pin levels
    output logic [2:0]                   pin_oe_q,         // Pin output enables
    input  wire logic                    phase_sync_pin,   // Phase sync pin, async
    input  wire logic                    internal_sync_in, // Internal sync pulse
    output logic [1:0]                   ramp_phase_q,     // Ramp phase in use
    output logic [7:0]                   ramp_phase_deg_q, // Ramp phase offset, degrees
    output logic                         ramp_sync_q,      // Phase sync pulse
    output logic                         ss_manual_q,      // Spread controller manual mode
    output logic                         ss_src_div2_q,    // Spread source is PLL over two
    output logic                         ss_random_en_q,   // Random spread enable
    output logic                         ss_triangle_en_q, // Triangle spread enable
    output logic [2:0]                   ss_dither_q,      // Random dither amount
    output logic [3:0]                   ss_triangle_ctrl_q // Triangle frequency and range
);
    import amp_regs_pkg::*;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic logic addr_hit(input byte_t addr, input byte_t ofs);
        addr_hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    byte_t pin_polarity_q;
    byte_t power_state_q;
    byte_t silence_status_q;
    byte_t phase_ctrl_q;
    byte_t ss_ctrl_a_q;
    byte_t ss_ctrl_b_q;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire logic hit_polarity = addr_hit(reg_addr, `OFS_PIN_OUTPUT_POLARITY);
    wire logic hit_chip_id  = addr_hit(reg_addr, `OFS_CHIP_IDENTIFIER);
    wire logic hit_power    = addr_hit(reg_addr, `OFS_POWER_STATE_REPORT);
    wire logic hit_silence  = addr_hit(reg_addr, `OFS_AUTO_SILENCE_STATUS);
    wire logic hit_phase    = addr_hit(reg_addr, `OFS_RAMP_PHASE_CONTROL);
    wire logic hit_ss_a     = addr_hit(reg_addr, `OFS_SPREAD_SPECTRUM_CONTROL_A);
    wire logic hit_ss_b     = addr_hit(reg_addr, `OFS_SPREAD_SPECTRUM_CONTROL_B);

    // Read-only registers have no write enable, so writes to them fall away
    wire logic wr_polarity = reg_wr & hit_polarity;
    wire logic wr_phase    = reg_wr & hit_phase;
    wire logic wr_ss_a     = reg_wr & hit_ss_a;
    wire logic wr_ss_b     = reg_wr & hit_ss_b;

    // ------------------------------------------------------------------------
    // Next values of writable registers
    // ------------------------------------------------------------------------
    // Reserved bits are stored whole and read back, but nothing downstream uses them
    wire byte_t pin_polarity_d = wr_polarity ? reg_wdata : pin_polarity_q;
    wire byte_t phase_ctrl_d   = wr_phase ? reg_wdata : phase_ctrl_q;
    wire byte_t ss_ctrl_a_d    = wr_ss_a ? reg_wdata : ss_ctrl_a_q;
    wire byte_t ss_ctrl_b_d    = wr_ss_b ? reg_wdata : ss_ctrl_b_q;

    // ------------------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------------------
    // Core drives these on the same clock; one register stage keeps reads stable
    wire byte_t power_state_d    = power_state_in;
    wire byte_t silence_status_d = {6'h00, right_silent_in, left_silent_in};

    wire logic in_play = (power_state_q[7:2] == 6'h00) && (power_state_q[1:0] == pwr_play);

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Unmapped offsets read as zero
    wire byte_t read_mux =
        hit_polarity ? pin_polarity_q   :
        hit_chip_id  ? CHIP_ID          :
        hit_power    ? power_state_q    :
        hit_silence  ? silence_status_q :
        hit_phase    ? phase_ctrl_q     :
        hit_ss_a     ? ss_ctrl_a_q      :
        hit_ss_b     ? ss_ctrl_b_q      :
                       `RST_READ_DATA;

    wire byte_t reg_rdata_d = reg_rd ? read_mux : reg_rdata_q;

    // ------------------------------------------------------------------------
    // Spread-spectrum controls
    // ------------------------------------------------------------------------
    wire logic ss_manual_d    = ss_ctrl_a_d[`BIT_SPREAD_MANUAL];
    wire logic ss_src_div2_d  = ss_ctrl_a_d[`BIT_SPREAD_PRE_DIV] & ss_manual_d;
    wire logic ss_random_d    = ss_ctrl_a_d[`BIT_RANDOM_SPREAD_EN];
    wire logic ss_triangle_d  = ss_ctrl_a_d[`BIT_TRIANGLE_SPREAD_EN];
    wire logic [2:0] dither_d = ss_ctrl_b_d[`FLD_RANDOM_DITHER_MSB:`FLD_RANDOM_DITHER_LSB];
    wire logic [3:0] tri_d    = ss_ctrl_b_d[`FLD_TRIANGLE_CTRL_MSB:`FLD_TRIANGLE_CTRL_LSB];

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_polarity_q   <= `RST_PIN_OUTPUT_POLARITY;
            power_state_q    <= `RST_POWER_STATE_REPORT;
            silence_status_q <= `RST_AUTO_SILENCE_STATUS;
            phase_ctrl_q     <= `RST_RAMP_PHASE_CONTROL;
            ss_ctrl_a_q      <= `RST_SPREAD_SPECTRUM_CONTROL_A;
            ss_ctrl_b_q      <= `RST_SPREAD_SPECTRUM_CONTROL_B;
        end
        else
        begin
            pin_polarity_q   <= pin_polarity_d;
            power_state_q    <= power_state_d;
            silence_status_q <= silence_status_d;
            phase_ctrl_q     <= phase_ctrl_d;
            ss_ctrl_a_q      <= ss_ctrl_a_d;
            ss_ctrl_b_q      <= ss_ctrl_b_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata_q  <= `RST_READ_DATA;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rdata_q  <= reg_rdata_d;
            reg_rvalid_q <= reg_rd;
        end
    end

    // ------------------------------------------------------------------------
    // Spread-spectrum outputs
    // ------------------------------------------------------------------------
    // Taken from the next register value so outputs follow a write with no extra lag
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ss_manual_q        <= 1'b0;
            ss_src_div2_q      <= 1'b0;
            ss_random_en_q     <= 1'b0;
            ss_triangle_en_q   <= 1'b0;
            ss_dither_q        <= 3'h0;
            ss_triangle_ctrl_q <= 4'h0;
        end
        else
        begin
            ss_manual_q        <= ss_manual_d;
            ss_src_div2_q      <= ss_src_div2_d;
            ss_random_en_q     <= ss_random_d;
            ss_triangle_en_q   <= ss_triangle_d;
            ss_dither_q        <= dither_d;
            ss_triangle_ctrl_q <= tri_d;
        end
    end

    // ------------------------------------------------------------------------
    // General pin polarity
    // ------------------------------------------------------------------------
    // Field bit order differs from pin numbering; reorder into pin index order
    wire pin_vec_t invert_by_pin =
        {pin_polarity_q[`BIT_INV_PIN2],
         pin_polarity_q[`BIT_INV_PIN1],
         pin_polarity_q[`BIT_INV_PIN0]};

    pin_polarity u_pin_polarity
    (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .invert    (invert_by_pin),
        .level_in  (pin_level_in),
        .oe_in     (pin_dir_out_in),
        .pin_out_q (pin_out_q),
        .pin_oe_q  (pin_oe_q)
    );

    // ------------------------------------------------------------------------
    // Ramp phase and synchronisation
    // ------------------------------------------------------------------------
    wire logic [1:0] phase_sel_fld = phase_ctrl_q[`FLD_RAMP_PHASE_MSB:`FLD_RAMP_PHASE_LSB];
    wire logic       sync_en_bit   = phase_ctrl_q[`BIT_PHASE_SYNC_EN];
    wire logic       sync_src_bit  = phase_ctrl_q[`BIT_PHASE_SYNC_SRC];

    ramp_phase_sync u_ramp_phase_sync
    (
        .clk_sys           (clk_sys),
        .rst_b             (rst_b),
        .phase_sel         (phase_sel_fld),
        .sync_en           (sync_en_bit),
        .sync_src_internal (sync_src_bit),
        .sync_pin          (phase_sync_pin),
        .internal_sync     (internal_sync_in),
        .in_play           (in_play),
        .ramp_phase_q      (ramp_phase_q),
        .ramp_phase_deg_q  (ramp_phase_deg_q),
        .ramp_sync_q       (ramp_sync_q)
    );

endmodule

`default_nettype wire

// ---- test/amp_status_ramp_ss_regs_assertions.sv ----
// Port-level checker for the status, pin polarity, ramp phase and spread-spectrum bank
`timescale 1ns/10ps
`default_nettype none

module amp_regs_checker
#(
    parameter logic [7:0] CHIP_ID = 8'h5A        // Arbitrary identifier value
)
(
    input  wire logic                    clk_sys,           // System clock
    input  wire logic                    rst_b,             // Async reset, active low
    input  wire amp_regs_pkg::byte_t     reg_addr,          // Register offset
    input  wire amp_regs_pkg::byte_t     reg_wdata,         // Write data
    input  wire logic                    reg_wr,            // Write strobe
    input  wire logic                    reg_rd,            // Read strobe
    input  wire logic [7:0]              reg_rdata_q,       // Read data
    input  wire logic                    reg_rvalid_q,      // Read data valid
    input  wire amp_regs_pkg::byte_t     power_state_in,    // Power state code
    input  wire logic                    right_silent_in,   // Right auto-muted
    input  wire logic                    left_silent_in,    // Left auto-muted
    input  wire logic [2:0]              pin_out_q,         // Driven pin levels
    input  wire logic [2:0]              pin_oe_q,          // Pin output enables
    input  wire logic [1:0]              ramp_phase_q,      // Ramp phase in use
    input  wire logic [7:0]              ramp_phase_deg_q,  // Phase offset, degrees
    input  wire logic                    ss_manual_q,       // Manual mode
    input  wire logic                    ss_src_div2_q,     // PLL over two source
    input  wire logic                    ss_random_en_q,    // Random spread enable
    input  wire logic                    ss_triangle_en_q,  // Triangle spread enable
    input  wire logic [2:0]              ss_dither_q,       // Dither amount
    input  wire logic [3:0]              ss_triangle_ctrl_q // Triangle control
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    read_answer_a: assert property (reg_rd |=> reg_rvalid_q) else $error("read not answered");
    no_spurious_a: assert property (!reg_rd |=> !reg_rvalid_q) else $error("valid without read");
    chip_id_a: assert property (reg_rd && reg_addr == 8'h67 |=> reg_rdata_q == CHIP_ID)
        else $error("identifier mismatch");
    power_report_a: assert property (reg_rd && reg_addr == 8'h68 |=> reg_rdata_q == $past(power_state_in, 2))
        else $error("power report mismatch");
    silence_report_a: assert property (reg_rd && reg_addr == 8'h69 |=>
        reg_rdata_q == {6'h00, $past(right_silent_in, 2), $past(left_silent_in, 2)}) else $error("silence mismatch");
    input_pin_quiet_a: assert property ((pin_out_q & ~pin_oe_q) == 3'h0) else $error("input pin driven");
    divider_gated_a: assert property (ss_src_div2_q |-> ss_manual_q) else $error("div2 outside manual");
    phase_degrees_a: assert property (ramp_phase_deg_q == {6'h00, ramp_phase_q} * 8'h2D)
        else $error("phase degrees mismatch");
    spread_enable_a: assert property (reg_wr && reg_addr == 8'h6B |=> ss_triangle_en_q == $past(reg_wdata[0])
        && ss_random_en_q == $past(reg_wdata[1]) && ss_manual_q == $past(reg_wdata[4])) else $error("enables");
    spread_fields_a: assert property (reg_wr && reg_addr == 8'h6C |=> ss_dither_q == $past(reg_wdata[6:4])
        && ss_triangle_ctrl_q == $past(reg_wdata[3:0])) else $error("spread fields mismatch");
endmodule

bind amp_status_ramp_ss_regs amp_regs_checker #(.CHIP_ID(CHIP_ID)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .power_state_in(power_state_in), .right_silent_in(right_silent_in),
    .left_silent_in(left_silent_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .ramp_phase_q(ramp_phase_q),
    .ramp_phase_deg_q(ramp_phase_deg_q), .ss_manual_q(ss_manual_q), .ss_src_div2_q(ss_src_div2_q),
    .ss_random_en_q(ss_random_en_q), .ss_triangle_en_q(ss_triangle_en_q), .ss_dither_q(ss_dither_q),
    .ss_triangle_ctrl_q(ss_triangle_ctrl_q));

`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the status, pin polarity, ramp phase and spread-spectrum bank
`timescale 1ns/10ps
`default_nettype none

module tb;
    import amp_regs_pkg::*;
    localparam logic [7:0] ID = 8'h3C;           // Arbitrary identifier value
    logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, right_silent_in = 1'b0;
    logic left_silent_in = 1'b0, phase_sync_pin = 1'b0, internal_sync_in = 1'b0;
    byte_t reg_addr = 8'h00, reg_wdata = 8'h00, power_state_in = 8'h00;
    pin_vec_t pin_level_in = 3'h0, pin_dir_out_in = 3'h0;
    logic [7:0] reg_rdata_q, ramp_phase_deg_q;
    logic reg_rvalid_q, ramp_sync_q, ss_manual_q, ss_src_div2_q, ss_random_en_q, ss_triangle_en_q;
    logic [2:0] pin_out_q, pin_oe_q, ss_dither_q;
    logic [1:0] ramp_phase_q;
    logic [3:0] ss_triangle_ctrl_q;
    int fail_count = 0, compares = 0, hits;
    // Rows: offset, written value, value read back
    logic [23:0] rows [7] = '{24'h66FDFD, 24'h6AF0F0, 24'h6BCCCC, 24'h6C7F7F, 24'h670000 | ID, 24'h705500, 24'h68FF00};

    amp_status_ramp_ss_regs #(.CHIP_ID(ID)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .power_state_in(power_state_in), .right_silent_in(right_silent_in),
        .left_silent_in(left_silent_in), .pin_level_in(pin_level_in), .pin_dir_out_in(pin_dir_out_in),
        .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .phase_sync_pin(phase_sync_pin),
        .internal_sync_in(internal_sync_in), .ramp_phase_q(ramp_phase_q), .ramp_phase_deg_q(ramp_phase_deg_q),
        .ramp_sync_q(ramp_sync_q), .ss_manual_q(ss_manual_q), .ss_src_div2_q(ss_src_div2_q),
        .ss_random_en_q(ss_random_en_q), .ss_triangle_en_q(ss_triangle_en_q), .ss_dither_q(ss_dither_q),
        .ss_triangle_ctrl_q(ss_triangle_ctrl_q));

    always #25 clk_sys = ~clk_sys;

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // Every drive lands 5 ns after a rising edge, clear of the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        cyc(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input byte_t a, input byte_t e);
        cyc(1);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk(reg_rvalid_q === 1'b1 && reg_rdata_q === e, "read back");
    endtask

    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        cyc(16);
        rst_b = 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        for (int i = 0; i < 4; i++)
        begin
            power_state_in = i[7:0];
            cyc(2);
            rd(8'h68, i[7:0]);
        end
        power_state_in = 8'h00;
        right_silent_in = 1'b1;
        cyc(2);
        rd(8'h69, 8'h02);
        right_silent_in = 1'b0;
        left_silent_in = 1'b1;
        cyc(2);
        rd(8'h69, 8'h01);
        pin_dir_out_in = 3'h7;
        wr(8'h66, 8'h01);
        cyc(2);
        chk(pin_out_q === 3'h2, "pin 1 invert");
        wr(8'h66, 8'h04);
        cyc(2);
        chk(pin_out_q === 3'h1, "pin 0 invert");
        pin_dir_out_in = 3'h6;
        pin_level_in = 3'h7;
        wr(8'h66, 8'h02);
        cyc(2);
        chk(pin_out_q === 3'h2 && pin_oe_q === 3'h6, "pin 2 invert");
        wr(8'h6B, 8'h20);
        chk(ss_src_div2_q === 1'b0 && ss_manual_q === 1'b0, "div2 out of manual");
        wr(8'h6B, 8'h31);
        chk({ss_src_div2_q, ss_manual_q, ss_random_en_q, ss_triangle_en_q} === 4'hD, "manual");
        wr(8'h6C, 8'h5A);
        chk(ss_dither_q === 3'h5 && ss_triangle_ctrl_q === 4'hA, "spread fields");
        wr(8'h6A, 8'h0C);
        cyc(3);
        chk(ramp_phase_q === 2'h3 && ramp_phase_deg_q === 8'h87, "phase 3");
        // Phase is taken only outside play, so a write in play must not move it
        power_state_in = 8'h03;
        cyc(2);
        wr(8'h6A, 8'h04);
        cyc(3);
        chk(ramp_phase_q === 2'h3, "phase frozen in play");
        power_state_in = 8'h00;
        wr(8'h6A, 8'h03);
        cyc(2);
        internal_sync_in = 1'b1;
        cyc(1);
        internal_sync_in = 1'b0;
        chk(ramp_sync_q === 1'b1, "internal sync");
        cyc(1);
        chk(ramp_sync_q === 1'b0, "sync pulse too long");
        wr(8'h6A, 8'h02);
        cyc(2);
        internal_sync_in = 1'b1;
        cyc(1);
        internal_sync_in = 1'b0;
        chk(ramp_sync_q === 1'b0, "sync disabled");
        cyc(1);
        wr(8'h6A, 8'h01);
        cyc(2);
        phase_sync_pin = 1'b1;
        hits = 0;
        repeat (8)
        begin
            cyc(1);
            if (ramp_sync_q === 1'b1)
                hits++;
        end
        chk(hits == 1, "pin sync");
        phase_sync_pin = 1'b0;
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        foreach (rows[i])
            rd(rows[i][23:16], (rows[i][23:16] == 8'h67) ? ID : 8'h00);
        report_and_stop();
    end
endmodule

`default_nettype wire
